// *** core/sadc_top.sv ***
// Conversion control, serial readout and power modes of the converter
`timescale 1ns/1ps
`default_nettype none

module sadc_top #(
  parameter int unsigned DATA_W = sadc_pkg::DATA_W,
  parameter int unsigned WAKE_SLEEP_CYC = sadc_pkg::WAKE_SLEEP_CYC
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Host link
  input wire logic sck_i,
  input wire logic convert_strobe_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Converter core
  input wire logic [DATA_W-1:0] sar_code_i,
  output logic busy_o,
  output logic sample_o,
  // Power state
  output logic nap_o,
  output logic sleep_o,
  output logic ready_o
);

  localparam int unsigned CONVERT_STROBE_W = $clog2(sadc_pkg::CONVERT_STROBE_CYC + 1);
  localparam int unsigned WAKE_W = $clog2(WAKE_SLEEP_CYC + 1);
  localparam logic [CONVERT_STROBE_W-1:0] CONVERT_STROBE_LOAD =
    CONVERT_STROBE_W'(sadc_pkg::CONVERT_STROBE_CYC - 1);
  localparam logic [WAKE_W-1:0] WAKE_NAP_LOAD =
    WAKE_W'(sadc_pkg::WAKE_NAP_CYC);
  localparam logic [WAKE_W-1:0] WAKE_SLEEP_LOAD = WAKE_W'(WAKE_SLEEP_CYC);
  localparam logic [2:0] NAP_CNT = 3'(sadc_pkg::NAP_PULSES);
  localparam logic [2:0] SLEEP_CNT = 3'(sadc_pkg::SLEEP_PULSES);

  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_ff;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================
  // Shift clock edges from the link domain
  sadc_edge_if edges ();

  sadc_link u_link (
    .sck_i(sck_i),
    .link_rst_n_i(rst_n),
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .edges(edges)
  );

  logic sck_edge;
  assign sck_edge = edges.sck_fall | edges.sck_rise;

  // ==========================================================
  // Strobe synchroniser and edge detect
  logic [2:0] strb_sync_ff;
  logic strb_hi;
  logic strb_rise;
  logic strb_fall;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      strb_sync_ff <= 3'h0;
    else
      strb_sync_ff <= {strb_sync_ff[1:0], convert_strobe_i};
  end

  assign strb_hi = strb_sync_ff[1];
  assign strb_rise = strb_sync_ff[1] & ~strb_sync_ff[2];
  assign strb_fall = ~strb_sync_ff[1] & strb_sync_ff[2];

  // ==========================================================
  // Power-down pulse counting
  logic [2:0] pulse_cnt_ff;
  logic [2:0] nxt_pulse_cnt;
  logic enter_nap;
  logic enter_sleep;
  sadc_pkg::sadc_pwr_t pwr_ff;

  always_comb
  begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (sck_edge)
      nxt_pulse_cnt = {2'h0, strb_rise};
    else if (strb_rise && (pulse_cnt_ff < SLEEP_CNT))
      nxt_pulse_cnt = pulse_cnt_ff + 3'h1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pulse_cnt_ff <= 3'h0;
    else
      pulse_cnt_ff <= nxt_pulse_cnt;
  end

  // Only counts built with a static shift clock reach these
  assign enter_nap = strb_rise && !sck_edge
                     && (nxt_pulse_cnt == NAP_CNT);
  assign enter_sleep = strb_rise && !sck_edge
                       && (nxt_pulse_cnt == SLEEP_CNT);

  // ==========================================================
  // Conversion sequencer
  sadc_pkg::sadc_convert_strobe_t convert_strobe_ff;
  sadc_pkg::sadc_convert_strobe_t nxt_convert_strobe;
  logic [CONVERT_STROBE_W-1:0] convert_strobe_cnt_ff;
  logic [DATA_W-1:0] result_ff;
  logic start_convert_strobe;
  logic convert_strobe_end;

  // The pulse that enters nap or sleep does not also start a conversion
  assign start_convert_strobe = strb_rise && (pwr_ff == sadc_pkg::PWR_ACTIVE)
                      && !enter_nap && !enter_sleep;
  assign convert_strobe_end = (convert_strobe_ff == sadc_pkg::CV_CONVERT)
                    && (convert_strobe_cnt_ff == '0);

  always_comb
  begin
    nxt_convert_strobe = convert_strobe_ff;
    case (convert_strobe_ff)
      sadc_pkg::CV_SAMPLE:
      begin
        if (start_convert_strobe)
          nxt_convert_strobe = sadc_pkg::CV_CONVERT;
      end
      sadc_pkg::CV_CONVERT:
      begin
        if (strb_fall)
          nxt_convert_strobe = sadc_pkg::CV_SAMPLE;
        else if (convert_strobe_end)
          nxt_convert_strobe = sadc_pkg::CV_DONE;
      end
      sadc_pkg::CV_DONE:
      begin
        if (strb_fall)
          nxt_convert_strobe = sadc_pkg::CV_SAMPLE;
      end
      default:
      begin
        nxt_convert_strobe = sadc_pkg::CV_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convert_strobe_ff <= sadc_pkg::CV_SAMPLE;
      busy_o <= 1'b0;
      sample_o <= 1'b1;
    end
    else
    begin
      convert_strobe_ff <= nxt_convert_strobe;
      busy_o <= (nxt_convert_strobe == sadc_pkg::CV_CONVERT);
      sample_o <= (nxt_convert_strobe == sadc_pkg::CV_SAMPLE);
    end
  end

  // Conversion timed by the core clock only, never by the shift clock
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      convert_strobe_cnt_ff <= '0;
    else if (start_convert_strobe && (convert_strobe_ff == sadc_pkg::CV_SAMPLE))
      convert_strobe_cnt_ff <= CONVERT_STROBE_LOAD;
    else if ((convert_strobe_ff == sadc_pkg::CV_CONVERT) && (convert_strobe_cnt_ff != '0))
      convert_strobe_cnt_ff <= convert_strobe_cnt_ff - CONVERT_STROBE_W'(1);
  end

  // Result of the conversion just finished, no extra latency
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      result_ff <= '0;
    else if (convert_strobe_end)
      result_ff <= sar_code_i;
  end

  // ==========================================================
  // Serial readout
  // Strobe low before the end truncates: the SAR code is taken as is
  logic [DATA_W-1:0] shreg_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg_ff <= '0;
      sdo_oe_o <= 1'b0;
    end
    else if (strb_hi)
    begin
      sdo_oe_o <= 1'b0;
    end
    else if (strb_fall)
    begin
      sdo_oe_o <= 1'b1;
      if (convert_strobe_ff == sadc_pkg::CV_CONVERT)
        shreg_ff <= sar_code_i;
      else
        shreg_ff <= result_ff;
    end
    else if (edges.sck_fall && sdo_oe_o)
    begin
      shreg_ff <= {shreg_ff[DATA_W-2:0], 1'b0};
    end
  end

  assign sdo_o = shreg_ff[DATA_W-1];

  // ==========================================================
  // Power modes and wake timing
  logic autonap_ff;
  logic [WAKE_W-1:0] wake_cnt_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      autonap_ff <= 1'b0;
    else if (convert_strobe_end)
      autonap_ff <= 1'b1;
    else if (start_convert_strobe || sck_edge)
      autonap_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pwr_ff <= sadc_pkg::PWR_ACTIVE;
    else if (enter_sleep)
      pwr_ff <= sadc_pkg::PWR_SLEEP;
    else if (enter_nap && (pwr_ff == sadc_pkg::PWR_ACTIVE))
      pwr_ff <= sadc_pkg::PWR_NAP;
    else if (edges.sck_fall)
      pwr_ff <= sadc_pkg::PWR_ACTIVE;
  end

  // Bias recovery counted so the core can flag unreliable results
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wake_cnt_ff <= '0;
    else if (edges.sck_fall && (pwr_ff == sadc_pkg::PWR_SLEEP))
      wake_cnt_ff <= WAKE_SLEEP_LOAD;
    else if (edges.sck_fall && (pwr_ff == sadc_pkg::PWR_NAP))
      wake_cnt_ff <= WAKE_NAP_LOAD;
    else if (wake_cnt_ff != '0)
      wake_cnt_ff <= wake_cnt_ff - WAKE_W'(1);
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nap_o <= 1'b0;
      sleep_o <= 1'b0;
      ready_o <= 1'b0;
    end
    else
    begin
      nap_o <= (pwr_ff == sadc_pkg::PWR_NAP) || autonap_ff;
      sleep_o <= (pwr_ff == sadc_pkg::PWR_SLEEP);
      ready_o <= (pwr_ff == sadc_pkg::PWR_ACTIVE)
                 && (wake_cnt_ff == '0);
    end
  end

endmodule // sadc_top

`default_nettype wire

// *** core/sadc_pkg.sv ***
// Shared constants and types of the sampling converter control block
`default_nettype none

package sadc_pkg;

  // ==========================================================
  // Helpers
  function automatic int unsigned cycles_ceil(input int unsigned t_ps,
                                              input int unsigned clk_ps);
    cycles_ceil = (t_ps + clk_ps - 1) / clk_ps;
    if (cycles_ceil == 0)
    begin
      cycles_ceil = 1;
    end
  endfunction

  // ==========================================================
  // Data layout
  localparam int unsigned DATA_W = 12;
  localparam int unsigned NAP_PULSES = 2;
  localparam int unsigned SLEEP_PULSES = 4;
  localparam int unsigned PULSE_CNT_W = 3;

  // ==========================================================
  // Timing, in picoseconds, and derived cycle counts
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned CONVERSION_TIME_PS = 247000;
  localparam int unsigned WAKE_NAP_PS = 50000;
  localparam int unsigned WAKE_SLEEP_PS = 1100000000;
  localparam int unsigned CONVERT_STROBE_CYC =
    cycles_ceil(CONVERSION_TIME_PS, CLK_PERIOD_PS);
  localparam int unsigned WAKE_NAP_CYC =
    cycles_ceil(WAKE_NAP_PS, CLK_PERIOD_PS);
  localparam int unsigned WAKE_SLEEP_CYC =
    cycles_ceil(WAKE_SLEEP_PS, CLK_PERIOD_PS);

  // ==========================================================
  // State encodings
  typedef enum logic [1:0] {
    CV_SAMPLE = 2'h0,
    CV_CONVERT = 2'h1,
    CV_DONE = 2'h2
  } sadc_convert_strobe_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_NAP = 2'h1,
    PWR_SLEEP = 2'h2
  } sadc_pwr_t;

endpackage

`default_nettype wire

// *** core/sadc_edge_if.sv ***
// Shift clock edge events carried into the core clock domain
`timescale 1ns/1ps
`default_nettype none

interface sadc_edge_if;
  logic sck_fall;
  logic sck_rise;

  modport src (
    output sck_fall,
    output sck_rise
  );

  modport dst (
    input sck_fall,
    input sck_rise
  );
endinterface

`default_nettype wire

// *** core/sadc_link.sv ***
// Shift clock domain edge toggles and their crossing into the core clock
`timescale 1ns/1ps
`default_nettype none

module sadc_link (
  // Link side
  input wire logic sck_i,
  input wire logic link_rst_n_i,
  // Core side
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  sadc_edge_if.src edges
);

  // ==========================================================
  // Link domain: one toggle per edge
  // Edges may stop between frames; a toggle loses nothing when they do
  logic fall_tgl_ff;
  logic rise_tgl_ff;

  always_ff @(negedge sck_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
      fall_tgl_ff <= 1'b0;
    else
      fall_tgl_ff <= ~fall_tgl_ff;
  end

  always_ff @(posedge sck_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
      rise_tgl_ff <= 1'b0;
    else
      rise_tgl_ff <= ~rise_tgl_ff;
  end

  // ==========================================================
  // Core domain: two-stage sync, third stage for the change
  logic [2:0] fall_sync_ff;
  logic [2:0] rise_sync_ff;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fall_sync_ff <= 3'h0;
      rise_sync_ff <= 3'h0;
    end
    else
    begin
      fall_sync_ff <= {fall_sync_ff[1:0], fall_tgl_ff};
      rise_sync_ff <= {rise_sync_ff[1:0], rise_tgl_ff};
    end
  end

  assign edges.sck_fall = fall_sync_ff[2] ^ fall_sync_ff[1];
  assign edges.sck_rise = rise_sync_ff[2] ^ rise_sync_ff[1];

endmodule // sadc_link

`default_nettype wire

// *** verif/sadc_props.sv ***
// Assertion checker of the converter control block ports
`timescale 1ns/1ps
`default_nettype none

module sadc_props #(
  parameter int unsigned DATA_W = 12,
  parameter int unsigned WAKE_SLEEP_CYC = 50
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Host link
  input wire logic sck_i,
  input wire logic convert_strobe_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  // Converter core
  input wire logic [DATA_W-1:0] sar_code_i,
  input wire logic busy_o,
  input wire logic sample_o,
  // Power state
  input wire logic nap_o,
  input wire logic sleep_o,
  input wire logic ready_o
);
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_hiz_strobe_high: assert property (
    convert_strobe_i [*5] |-> !sdo_oe_o)
    else $error("serial output driven while strobe high");
  a_oe_on_fall: assert property (
    $fell(convert_strobe_i) ##1 !convert_strobe_i [*5] |-> sdo_oe_o)
    else $error("serial output not enabled after strobe fall");
  a_sample_low: assert property (
    !convert_strobe_i [*6] |-> sample_o)
    else $error("not sampling while strobe low");
  a_busy_cause: assert property (
    $rose(busy_o) |-> convert_strobe_i && !sample_o)
    else $error("conversion without strobe or while sampling");
  a_convert_strobe_length: assert property (
    $rose(busy_o) |-> ##60 busy_o ##[1:4] !busy_o)
    else $error("conversion length off");
  a_auto_nap: assert property (
    $fell(busy_o) |-> ##[0:2] nap_o)
    else $error("no nap after conversion");
  a_hold_bit: assert property (
    (!convert_strobe_i && $stable(sck_i)) [*8] |-> $stable(sdo_o))
    else $error("serial data moved without a shift edge");
  a_wake_pulse: assert property (
    (nap_o || sleep_o) && $fell(sck_i) |-> ##[1:8] !nap_o && !sleep_o)
    else $error("no wake after shift clock pulse");
endmodule // sadc_props

bind sadc_top sadc_props #(
  .DATA_W(DATA_W),
  .WAKE_SLEEP_CYC(WAKE_SLEEP_CYC)
) u_props (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .sck_i(sck_i),
  .convert_strobe_i(convert_strobe_i),
  .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o),
  .sar_code_i(sar_code_i),
  .busy_o(busy_o),
  .sample_o(sample_o),
  .nap_o(nap_o),
  .sleep_o(sleep_o),
  .ready_o(ready_o)
);

`default_nettype wire

// *** verif/sadc_host.sv ***
// Host model driving the strobe and the shift clock
`timescale 1ns/1ps
`default_nettype none

module sadc_host (
  // Core clock and serial line
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  // Host drives
  output var logic convert_strobe_o,
  output var logic sck_o
);
  // ==========================================================
  // Idle levels, shift clock parked high
  initial
  begin
    convert_strobe_o = 1'b0;
    sck_o = 1'b1;
  end

  // ==========================================================
  // Strobe pulse, shift clock kept still throughout
  task automatic pulse(input int hi);
    @(posedge ref_clk_i);
    #1 convert_strobe_o = 1'b1;
    repeat (hi) @(posedge ref_clk_i);
    #1 convert_strobe_o = 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask

  // ==========================================================
  // Read n bits, the first after 41.3 ns with no clock pulse, each later one 80 ns after the rise that follows a fall
  task automatic read(input int n, output logic [15:0] d);
    d = 16'h0000;
    #41.3;
    for (int i = 0; i < n; i++)
    begin
      if (i > 0)
      begin
        sck_o = 1'b0;
        #80;
        sck_o = 1'b1;
        #80;
      end
      d = {d[14:0], sdo_i};
    end
    #20;
  endtask

  // ==========================================================
  // Single wake pulse; deep sleep needs reference recovery
  task automatic wake(input bit deep);
    #1.3 sck_o = 1'b0;
    #80;
    sck_o = 1'b1;
    #80;
    if (deep)
    begin
      repeat (60) @(posedge ref_clk_i);
    end
  endtask
endmodule // sadc_host

`default_nettype wire

// *** verif/sadc_top_bench.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none

module sadc_top_bench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [11:0] code = 12'h000;
  logic flip = 1'b0;
  wire logic convert_strobe;
  wire logic sck;
  wire logic sdo;
  wire logic oe;
  wire logic busy;
  wire logic smp;
  wire logic nap;
  wire logic slp;
  wire logic rdy;
  int failures = 0;
  int checked = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, floating line pattern and timeout
  always #2 ref_clk_i = ~ref_clk_i;
  // Released line shows a toggling level, never a stale bit
  always @(posedge ref_clk_i) flip <= ~flip;
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // Instances
  sadc_top #(.WAKE_SLEEP_CYC(50)) dut (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .sck_i(sck),
    .convert_strobe_i(convert_strobe),
    .sdo_o(sdo),
    .sdo_oe_o(oe),
    .sar_code_i(code),
    .busy_o(busy),
    .sample_o(smp),
    .nap_o(nap),
    .sleep_o(slp),
    .ready_o(rdy)
  );
  sadc_host host (
    .ref_clk_i(ref_clk_i),
    .sdo_i(oe ? sdo : flip),
    .convert_strobe_o(convert_strobe),
    .sck_o(sck)
  );

  // ==========================================================
  // Reporting
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, exp, input string what);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic frame(input logic [11:0] c);
    logic [15:0] d;
    @(posedge ref_clk_i);
    #1 code = c;
    fork
      host.pulse(70);
      begin
        repeat (30) @(posedge ref_clk_i);
        cmp({oe, busy, smp}, 3'b010, "converting");
        repeat (38) @(posedge ref_clk_i);
        cmp({busy, nap}, 2'b01, "auto nap");
      end
    join
    host.read(16, d);
    cmp(d, {c, 4'h0}, "result");
  endtask

  // Distinct codes back to back expose any stale result
  task automatic t_read();
    frame(12'ha5c);
    frame(12'hfff);
    frame(12'h001);
  endtask

  task automatic t_power();
    host.pulse(70);
    // Auto nap alone also shows nap, so the refused start tells them apart
    fork
      host.pulse(70);
      begin
        repeat (30) @(posedge ref_clk_i);
        cmp(busy, 1'b0, "second pulse converted");
      end
    join
    cmp({nap, slp}, 2'b10, "nap entry");
    host.wake(1'b0);
    cmp({nap, slp}, 2'b00, "nap wake");
    repeat (3) host.pulse(70);
    host.wake(1'b0);
    repeat (3) host.pulse(70);
    cmp(slp, 1'b0, "count cleared");
    host.pulse(70);
    cmp(slp, 1'b1, "sleep entry");
    fork
      host.wake(1'b1);
      begin
        #180;
        cmp({slp, rdy}, 2'b00, "sleep wake");
      end
    join
    cmp(rdy, 1'b1, "ready after wake");
    frame(12'h3c6);
  endtask

  initial
  begin
    repeat (14) @(posedge ref_clk_i);
    cmp({oe, busy, smp, nap, slp, rdy, sdo}, 7'b0010000, "reset");
    repeat (2) @(posedge ref_clk_i);
    #1 rstn_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    t_read();
    t_power();
    end_sim();
  end
endmodule // sadc_top_bench

`default_nettype wire
